/* File: verilog/dlac_pkg.sv */
// Shared constants, types and state layout of the dual attenuator control.
// Assumes one 100 MHz system clock and a synchronous active-low reset.
package dlac_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned WIN_MS = 50;
  // Longest window, rounded down to whole cycles
  localparam int unsigned WIN_CYC = (CLK_HZ / 1000) * WIN_MS;
  localparam int TMR_W = 23;
  localparam logic [TMR_W-1:0] TMR_ONE = 23'h00_0001;

  // ----------------------------------------------------------------
  // Serial addressing and command decode
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_HI = 4'h5;
  localparam logic [1:0] SEL_W0 = 2'h0;
  localparam logic [1:0] SEL_W1 = 2'h1;
  localparam logic [1:0] SEL_CFG = 2'h2;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [1:0] RD_LAST = 2'h2;

  // ----------------------------------------------------------------
  // Setup register layout and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_RST = 8'h87;
  localparam logic [4:0] CFG_FIXED = 5'h10;
  localparam int CFG_TAPER = 0;
  localparam int CFG_ZC = 1;
  localparam int CFG_VOL = 2;
  localparam logic [5:0] MUTE_FINE = 6'h3f;
  localparam logic [5:0] MUTE_COARSE = 6'h21;

  // ----------------------------------------------------------------
  // Taper tables
  // ----------------------------------------------------------------
  localparam logic [5:0] CODE_12 = 6'h0c;
  localparam logic [5:0] CODE_24 = 6'h18;
  localparam logic [5:0] CODE_32 = 6'h20;
  localparam logic [6:0] DB_12 = 7'h0c;
  localparam logic [6:0] DB_36 = 7'h24;
  localparam logic [6:0] DB_MUTE = 7'h50;

  // ----------------------------------------------------------------
  // Synchronised pin indices
  // ----------------------------------------------------------------
  localparam int PIN_N = 8;
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_CEN = 2;
  localparam int PIN_ZC0 = 3;
  localparam int PIN_STRAP = 5;

  typedef enum logic [2:0] {
    ST_LOAD = 3'h0,
    ST_IDLE = 3'h1,
    ST_ADDR = 3'h2,
    ST_ACK_ADDR = 3'h3,
    ST_CMD = 3'h4,
    ST_ACK_CMD = 3'h5,
    ST_TX = 3'h6,
    ST_RX_ACK = 3'h7
  } dlac_state_t;

  typedef struct packed {
    dlac_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic mack;
    logic [1:0] idx;
    logic sda_oe;
    logic sda_out;
    logic [7:0] cfg;
    logic [1:0][5:0] wip;
    logic [1:0][5:0] pend;
    logic [1:0] pnd;
    logic [TMR_W-1:0] tmr;
    logic nv_arm;
    logic nv_req;
    logic nv_wr;
  } dlac_regs_t;

endpackage

/* File: verilog/dlac_pin_sync.sv */
// Three-stage synchroniser bank with agreement filter and edge pulses.
// Assumes every input is asynchronous to clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module dlac_pin_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Pins
  input wire logic [W-1:0] pin_i,
  // Filtered level and edges
  output logic [W-1:0] lvl_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } dlac_sync_t;

  dlac_sync_t sync_r;
  dlac_sync_t sync_nxt;
  logic [W-1:0] agree;

  // Only the second and third stages are compared
  always_comb
  begin
    agree = ~(sync_r.s2 ^ sync_r.s3);
    sync_nxt = sync_r;
    sync_nxt.s1 = pin_i;
    sync_nxt.s2 = sync_r.s1;
    sync_nxt.s3 = sync_r.s2;
    sync_nxt.lvl = (agree & sync_r.s3) | (~agree & sync_r.lvl);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      sync_r <= '1;
    else
      sync_r <= sync_nxt;
  end

  // Edges come out one cycle early to leave room in short clock lows
  assign lvl_o = sync_r.lvl;
  assign rise_o = agree & sync_r.s3 & ~sync_r.lvl;
  assign fall_o = agree & ~sync_r.s3 & sync_r.lvl;

endmodule // dlac_pin_sync
`default_nettype wire

/* File: verilog/dlac_taper.sv */
// Registered code-to-attenuation lookup for both channels.
// Assumes the taper select is shared by both channels.
`timescale 1ns/1ps
`default_nettype none
module dlac_taper (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Codes and taper
  input wire logic coarse_i,
  input wire logic [1:0][5:0] code_i,
  // Attenuation in dB
  output logic [1:0][6:0] db_o
);

  logic [1:0][6:0] db_r;
  logic [1:0][6:0] db_nxt;

  function automatic logic [6:0] dlac_db(input logic [5:0] code, input logic coarse);
    logic [6:0] c;
    c = {1'b0, code};
    if (!coarse)
      dlac_db = (code == dlac_pkg::MUTE_FINE) ? dlac_pkg::DB_MUTE : c;
    else if (code <= dlac_pkg::CODE_12)
      dlac_db = c;
    else if (code <= dlac_pkg::CODE_24)
      dlac_db = 7'((c << 1) - {1'b0, dlac_pkg::CODE_12});
    else if (code <= dlac_pkg::CODE_32)
      dlac_db = 7'(dlac_pkg::DB_36 + 7'(3 * (code - dlac_pkg::CODE_24)));
    else
      dlac_db = dlac_pkg::DB_MUTE;
  endfunction

  always_comb
  begin
    for (int ch = 0; ch < 2; ch++)
      db_nxt[ch] = dlac_db(code_i[ch], coarse_i);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      db_r <= {dlac_pkg::DB_MUTE, dlac_pkg::DB_MUTE};
    else
      db_r <= db_nxt;
  end

  assign db_o = db_r;

endmodule // dlac_taper
`default_nettype wire

/* File: verilog/dlac_top.sv */
// Dual attenuator control: two-wire serial slave, wiper and setup
// registers, zero-crossing window and storage write request.
// Assumes pins are asynchronous and the storage cells sit outside.
//
// Functional notes
// - One taper setting drives both channels.
// - Fine taper: 1 dB steps, 63 mutes.
// - Coarse taper: 1/2/3 dB steps, 33 mutes.
// - Gated wiper command acknowledge opens 50 ms window.
// - Gated: each channel applies at zero crossing.
// - Window expiry applies any still-pending wiper.
// - Ungated: apply wiper right at acknowledge.
// - Top bits select wiper 0, wiper 1, setup.
// - Command top bits 11: no action at all.
// - Six low bits become the wiper code.
// - Setup written only with bits 7:6 = 10.
// - Setup bits 5 to 3 are ignored.
// - Bit 2: 0 nonvolatile, 1 volatile wipers.
// - Volatile storage: wipers start muted.
// - Bit 1 enables zero-crossing gating.
// - Bit 0 selects fine or coarse taper.
// - Storage write after stop, after window if gated.
// - Reads cycle wiper 0, wiper 1, setup.
// - Answer only address 0101 plus straps.
// - Ignore the bus while enable is high.
`timescale 1ns/1ps
`default_nettype none
module dlac_top #(
  parameter int unsigned WIN_CYC = dlac_pkg::WIN_CYC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic comm_en_n_i,
  input wire logic addr_strap_0_i,
  input wire logic addr_strap_1_i,
  input wire logic addr_strap_2_i,
  // Zero-crossing indications, high while terminals are equal
  input wire logic [1:0] zc_i,
  // Stored settings restored after reset
  input wire logic [7:0] nv_setup_i,
  input wire logic [5:0] nv_wiper0_i,
  input wire logic [5:0] nv_wiper1_i,
  // Applied settings
  output logic [5:0] wiper0_o,
  output logic [5:0] wiper1_o,
  output logic [6:0] atten0_db_o,
  output logic [6:0] atten1_db_o,
  output logic [7:0] setup_o,
  // Storage write strobe, data on wiper and setup outputs
  output logic nv_wr_o
);

  localparam logic [dlac_pkg::TMR_W-1:0] WIN_LOAD = dlac_pkg::TMR_W'(WIN_CYC);

  dlac_pkg::dlac_regs_t r_r;
  dlac_pkg::dlac_regs_t r_nxt;
  logic [dlac_pkg::PIN_N-1:0] pins;
  logic [dlac_pkg::PIN_N-1:0] lvl;
  logic [dlac_pkg::PIN_N-1:0] rise;
  logic [dlac_pkg::PIN_N-1:0] fall;
  logic [1:0][6:0] db;

  // ----------------------------------------------------------------
  // Pin synchronisers and taper lookup
  // ----------------------------------------------------------------
  assign pins = {addr_strap_2_i, addr_strap_1_i, addr_strap_0_i, zc_i,
                 comm_en_n_i, sda_i, scl_i};

  dlac_pin_sync #(
    .W(dlac_pkg::PIN_N)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .pin_i(pins),
    .lvl_o(lvl),
    .rise_o(rise),
    .fall_o(fall)
  );

  dlac_taper u_taper (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .coarse_i(r_r.cfg[dlac_pkg::CFG_TAPER]),
    .code_i(r_r.wip),
    .db_o(db)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] rd_byte(input dlac_pkg::dlac_regs_t r, input logic [1:0] idx);
    unique case (idx)
      2'h0: rd_byte = {dlac_pkg::SEL_W0, r.wip[0]};
      2'h1: rd_byte = {dlac_pkg::SEL_W1, r.wip[1]};
      default: rd_byte = r.cfg;
    endcase
  endfunction

  function automatic logic [5:0] mute_code(input logic coarse);
    mute_code = coarse ? dlac_pkg::MUTE_COARSE : dlac_pkg::MUTE_FINE;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic scl_hi;
  logic start_ev;
  logic stop_ev;
  logic zc_on;
  logic [2:0] strap;
  logic [7:0] tx;

  always_comb
  begin
    scl_hi = lvl[dlac_pkg::PIN_SCL];
    start_ev = scl_hi & fall[dlac_pkg::PIN_SDA];
    stop_ev = scl_hi & rise[dlac_pkg::PIN_SDA];
    zc_on = r_r.cfg[dlac_pkg::CFG_ZC];
    strap = lvl[dlac_pkg::PIN_STRAP +: 3];
    tx = '0;
    r_nxt = r_r;
    r_nxt.nv_wr = 1'b0;
    r_nxt.sda_out = 1'b0;

    // Zero-crossing window
    if (r_r.tmr != '0)
    begin
      r_nxt.tmr = r_r.tmr - dlac_pkg::TMR_ONE;
      for (int ch = 0; ch < 2; ch++)
      begin
        if (r_r.pnd[ch] && (lvl[dlac_pkg::PIN_ZC0 + ch] || r_r.tmr == dlac_pkg::TMR_ONE))
        begin
          r_nxt.wip[ch] = r_r.pend[ch];
          r_nxt.pnd[ch] = 1'b0;
        end
      end
    end

    // Storage write waits for stop and, with gating on, for the window to close
    if (r_r.nv_req && (!zc_on || r_r.tmr == '0))
    begin
      r_nxt.nv_wr = 1'b1;
      r_nxt.nv_req = 1'b0;
    end

    unique case (r_r.st)
      dlac_pkg::ST_LOAD:
      begin
        r_nxt.cfg = {dlac_pkg::CFG_FIXED, nv_setup_i[2:0]};
        for (int ch = 0; ch < 2; ch++)
          r_nxt.wip[ch] = nv_setup_i[dlac_pkg::CFG_VOL] ?
            mute_code(nv_setup_i[dlac_pkg::CFG_TAPER]) :
            (ch == 0 ? nv_wiper0_i : nv_wiper1_i);
        r_nxt.st = dlac_pkg::ST_IDLE;
      end
      dlac_pkg::ST_IDLE:
        r_nxt.sda_oe = 1'b0;
      dlac_pkg::ST_ADDR, dlac_pkg::ST_CMD:
      begin
        if (rise[dlac_pkg::PIN_SCL] && r_r.cnt != dlac_pkg::BYTE_BITS)
        begin
          r_nxt.sh = {r_r.sh[6:0], lvl[dlac_pkg::PIN_SDA]};
          r_nxt.cnt = r_r.cnt + 4'h1;
        end
        else if (fall[dlac_pkg::PIN_SCL] && r_r.cnt == dlac_pkg::BYTE_BITS)
        begin
          r_nxt.cnt = '0;
          if (r_r.st == dlac_pkg::ST_ADDR)
          begin
            if (r_r.sh[7:4] == dlac_pkg::ADDR_HI && r_r.sh[3:1] == strap)
            begin
              r_nxt.rw = r_r.sh[0];
              r_nxt.sda_oe = 1'b1;
              r_nxt.st = dlac_pkg::ST_ACK_ADDR;
            end
            else
              r_nxt.st = dlac_pkg::ST_IDLE;
          end
          else if (r_r.sh[7:6] == dlac_pkg::SEL_CFG)
          begin
            // Bits 5 to 3 are not kept
            r_nxt.cfg = {dlac_pkg::CFG_FIXED, r_r.sh[2:0]};
            r_nxt.nv_arm = 1'b1;
            r_nxt.sda_oe = 1'b1;
            r_nxt.st = dlac_pkg::ST_ACK_CMD;
          end
          else if (r_r.sh[7] == 1'b0)
          begin
            r_nxt.sda_oe = 1'b1;
            r_nxt.st = dlac_pkg::ST_ACK_CMD;
            if (!r_r.cfg[dlac_pkg::CFG_VOL])
              r_nxt.nv_arm = 1'b1;
            if (zc_on)
            begin
              r_nxt.pend[r_r.sh[6]] = r_r.sh[5:0];
              r_nxt.pnd[r_r.sh[6]] = 1'b1;
              r_nxt.tmr = WIN_LOAD;
            end
            else
            begin
              r_nxt.wip[r_r.sh[6]] = r_r.sh[5:0];
              r_nxt.pnd[r_r.sh[6]] = 1'b0;
            end
          end
          else
            r_nxt.st = dlac_pkg::ST_IDLE;
        end
      end
      dlac_pkg::ST_ACK_ADDR:
      begin
        if (fall[dlac_pkg::PIN_SCL])
        begin
          if (r_r.rw)
          begin
            tx = rd_byte(r_r, 2'h0);
            r_nxt.idx = 2'h0;
            r_nxt.sh = tx;
            r_nxt.sda_oe = ~tx[7];
            r_nxt.st = dlac_pkg::ST_TX;
          end
          else
          begin
            r_nxt.sda_oe = 1'b0;
            r_nxt.st = dlac_pkg::ST_CMD;
          end
        end
      end
      dlac_pkg::ST_ACK_CMD:
      begin
        if (fall[dlac_pkg::PIN_SCL])
        begin
          r_nxt.sda_oe = 1'b0;
          r_nxt.st = dlac_pkg::ST_CMD;
        end
      end
      dlac_pkg::ST_TX:
      begin
        if (fall[dlac_pkg::PIN_SCL])
        begin
          if (r_r.cnt == dlac_pkg::BIT_LAST)
          begin
            r_nxt.cnt = '0;
            r_nxt.sda_oe = 1'b0;
            r_nxt.st = dlac_pkg::ST_RX_ACK;
          end
          else
          begin
            r_nxt.cnt = r_r.cnt + 4'h1;
            r_nxt.sh = {r_r.sh[6:0], 1'b0};
            r_nxt.sda_oe = ~r_r.sh[6];
          end
        end
      end
      dlac_pkg::ST_RX_ACK:
      begin
        if (rise[dlac_pkg::PIN_SCL])
          r_nxt.mack = ~lvl[dlac_pkg::PIN_SDA];
        else if (fall[dlac_pkg::PIN_SCL])
        begin
          if (r_r.mack)
          begin
            // Wraps back to wiper 0 after the setup byte
            r_nxt.idx = (r_r.idx == dlac_pkg::RD_LAST) ? 2'h0 : r_r.idx + 2'h1;
            tx = rd_byte(r_r, r_nxt.idx);
            r_nxt.sh = tx;
            r_nxt.sda_oe = ~tx[7];
            r_nxt.st = dlac_pkg::ST_TX;
          end
          else
            r_nxt.st = dlac_pkg::ST_IDLE;
        end
      end
    endcase

    // Bus conditions override the byte engine
    if (r_r.st != dlac_pkg::ST_LOAD)
    begin
      if (lvl[dlac_pkg::PIN_CEN])
      begin
        r_nxt.st = dlac_pkg::ST_IDLE;
        r_nxt.sda_oe = 1'b0;
        r_nxt.cnt = '0;
      end
      else if (start_ev)
      begin
        r_nxt.st = dlac_pkg::ST_ADDR;
        r_nxt.sda_oe = 1'b0;
        r_nxt.cnt = '0;
      end
      else if (stop_ev)
      begin
        r_nxt.st = dlac_pkg::ST_IDLE;
        r_nxt.sda_oe = 1'b0;
        r_nxt.cnt = '0;
        if (r_r.nv_arm)
        begin
          r_nxt.nv_arm = 1'b0;
          r_nxt.nv_req = 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      r_r <= '0;
      r_r.st <= dlac_pkg::ST_LOAD;
      r_r.cfg <= dlac_pkg::CFG_RST;
      r_r.wip <= {dlac_pkg::MUTE_COARSE, dlac_pkg::MUTE_COARSE};
    end
    else
      r_r <= r_nxt;
  end

  assign sda_o = r_r.sda_out;
  assign sda_oe_o = r_r.sda_oe;
  assign wiper0_o = r_r.wip[0];
  assign wiper1_o = r_r.wip[1];
  assign atten0_db_o = db[0];
  assign atten1_db_o = db[1];
  assign setup_o = r_r.cfg;
  assign nv_wr_o = r_r.nv_wr;

endmodule // dlac_top
`default_nettype wire

/* File: tb/dlac_monitor.sv */
// Port assertions for the dual attenuator control.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module dlac_monitor #(
  parameter int unsigned WIN_CYC = 200
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Watched ports
  input wire logic comm_en_n_i,
  input wire logic sda_oe_o,
  input wire logic [5:0] wiper0_o,
  input wire logic [5:0] wiper1_o,
  input wire logic [6:0] atten0_db_o,
  input wire logic [6:0] atten1_db_o,
  input wire logic [7:0] setup_o,
  input wire logic nv_wr_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  // Cycles since the slave last pulled the data line; reset counts as a pull
  logic [23:0] since_oe_r;
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i || sda_oe_o)
      since_oe_r <= 24'h00_0000;
    else if (since_oe_r != 24'hff_ffff)
      since_oe_r <= since_oe_r + 24'h00_0001;
  end

  chk_fine_step: assert property (
    (!setup_o[0] && wiper0_o != 6'h3f) |=> atten0_db_o == {1'b0, $past(wiper0_o)})
    else $error("fine step attenuation wrong");
  chk_fine_mute: assert property (
    (!setup_o[0] && wiper1_o == 6'h3f) |=> atten1_db_o == 7'h50)
    else $error("fine mute attenuation wrong");
  chk_coarse_low: assert property (
    (setup_o[0] && wiper1_o <= 6'h0c) |=> atten1_db_o == {1'b0, $past(wiper1_o)})
    else $error("coarse low attenuation wrong");
  chk_coarse_mid: assert property (
    (setup_o[0] && wiper0_o > 6'h0c && wiper0_o <= 6'h18)
    |=> atten0_db_o == {$past(wiper0_o), 1'b0} - 7'h0c)
    else $error("coarse middle attenuation wrong");
  chk_coarse_mute: assert property (
    (setup_o[0] && wiper0_o > 6'h20) |=> atten0_db_o == 7'h50)
    else $error("coarse mute attenuation wrong");
  chk_setup_fixed: assert property (setup_o[7:3] == 5'h10)
    else $error("setup upper bits wrong");
  chk_store_pulse: assert property (nv_wr_o |=> !nv_wr_o)
    else $error("store strobe longer than one cycle");
  chk_idle_quiet: assert property (comm_en_n_i [*8] |-> !sda_oe_o)
    else $error("data line pulled while disabled");
  chk_apply_bound: assert property (
    ($changed(wiper0_o) || $changed(wiper1_o)) |-> since_oe_r <= WIN_CYC + 16)
    else $error("wiper moved outside its window");

  cover property (nv_wr_o);
  cover property (sda_oe_o && setup_o[1]);
  cover property (setup_o[0] && $changed(wiper1_o));
endmodule // dlac_monitor

bind dlac_top dlac_monitor #(.WIN_CYC(WIN_CYC)) u_monitor (
  .clk_sys_i(clk_sys_i),
  .rstn_i(rstn_i),
  .comm_en_n_i(comm_en_n_i),
  .sda_oe_o(sda_oe_o),
  .wiper0_o(wiper0_o),
  .wiper1_o(wiper1_o),
  .atten0_db_o(atten0_db_o),
  .atten1_db_o(atten1_db_o),
  .setup_o(setup_o),
  .nv_wr_o(nv_wr_o)
);
`default_nettype wire

/* File: tb/dlac_i2c_master.sv */
// Two-wire bus master model: clock and open-drain data drive.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module dlac_i2c_master (
  // Clock
  input wire logic clk_sys_i,
  // Bus
  input wire logic sda_line_i,
  output logic scl_o,
  output logic sda_o
);
  // Eight-cycle phases so the slave answer settles before each rise
  localparam int PH = 8;
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic start_cond();
    tick(PH / 2);
    sda_o <= 1'b1;
    tick(PH / 2);
    scl_o <= 1'b1;
    tick(PH);
    sda_o <= 1'b0;
    tick(PH);
    scl_o <= 1'b0;
  endtask
  task automatic stop_cond();
    tick(PH / 2);
    sda_o <= 1'b0;
    tick(PH / 2);
    scl_o <= 1'b1;
    tick(PH);
    sda_o <= 1'b1;
    tick(PH);
  endtask
  // Drive 1 to release; wire level is read at the end of the high phase
  task automatic bit_io(input logic b, output logic r);
    tick(PH / 2);
    sda_o <= b;
    tick(PH / 2);
    scl_o <= 1'b1;
    tick(PH);
    r = sda_line_i;
    scl_o <= 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(last, ack);
  endtask
endmodule // dlac_i2c_master
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the dual attenuator control.
// Assumes the master model and a 200-cycle window for speed.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int unsigned WIN = 200;
  localparam logic [6:0] DEV = 7'h2d;
  logic clk_sys_i;
  logic rstn_i;
  logic comm_en_n;
  logic [2:0] strap;
  logic [1:0] zc;
  logic [7:0] nv_setup;
  logic [5:0] nv_w0;
  logic [5:0] nv_w1;
  logic scl;
  logic m_sda;
  logic sda_line;
  logic sda_drv;
  logic sda_oe;
  logic [5:0] w0;
  logic [5:0] w1;
  logic [6:0] db0;
  logic [6:0] db1;
  logic [7:0] setup;
  logic nv_wr;
  int errors;
  int tests_run;
  int cyc;
  int nv_pulses;
  assign sda_line = m_sda & ~(sda_oe & ~sda_drv);

  dlac_top #(.WIN_CYC(WIN)) dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_drv), .sda_oe_o(sda_oe), .comm_en_n_i(comm_en_n),
    .addr_strap_0_i(strap[0]), .addr_strap_1_i(strap[1]), .addr_strap_2_i(strap[2]),
    .zc_i(zc), .nv_setup_i(nv_setup), .nv_wiper0_i(nv_w0), .nv_wiper1_i(nv_w1),
    .wiper0_o(w0), .wiper1_o(w1), .atten0_db_o(db0), .atten1_db_o(db1),
    .setup_o(setup), .nv_wr_o(nv_wr));
  dlac_i2c_master mst (.clk_sys_i(clk_sys_i), .sda_line_i(sda_line), .scl_o(scl),
    .sda_o(m_sda));

  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (nv_wr === 1'b1)
      nv_pulses <= nv_pulses + 1;
    if (cyc == 60000)
    begin
      errors = errors + 1;
      end_of_test();
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr2(input logic [6:0] adr, input logic [7:0] c0, input logic [7:0] c1,
                     output logic aa, output logic ac);
    logic [7:0] q;
    logic a1;
    mst.start_cond();
    mst.xfer({adr, 1'b0}, 1'b1, q, aa);
    mst.xfer(c0, 1'b1, q, ac);
    mst.xfer(c1, 1'b1, q, a1);
    mst.stop_cond();
    repeat (8) @(posedge clk_sys_i);
  endtask
  task automatic t_power(input logic [7:0] s, input logic [5:0] a, input logic [5:0] b,
                         input logic [7:0] es, input logic [5:0] e0, input logic [5:0] e1);
    nv_setup <= s;
    nv_w0 <= a;
    nv_w1 <= b;
    rstn_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    check("setup", setup, es);
    check("wiper0", w0, e0);
    check("wiper1", w1, e1);
  endtask
  task automatic t_taper(input logic [5:0] code, input logic [6:0] db);
    logic aa;
    logic ac;
    wr2(DEV, {2'b00, code}, {2'b01, code}, aa, ac);
    check("wiper0", w0, code);
    check("wiper1", w1, code);
    check("atten0", db0, db);
    check("atten1", db1, db);
  endtask
  task automatic t_coarse();
    logic [5:0] c [8] = '{6'h00, 6'h0c, 6'h0d, 6'h18, 6'h19, 6'h20, 6'h21, 6'h28};
    logic [6:0] d [8] = '{7'h00, 7'h0c, 7'h0e, 7'h24, 7'h27, 7'h3c, 7'h50, 7'h50};
    int p;
    p = nv_pulses;
    for (int i = 0; i < 8; i++)
      t_taper(c[i], d[i]);
    check("volatile store", 8'(nv_pulses - p), 8'h00);
  endtask
  task automatic t_refuse();
    logic aa;
    logic ac;
    wr2(DEV, 8'hc2, 8'h05, aa, ac);
    check("bad cmd ack", ac, 1'b1);
    check("bad cmd wiper", w0, 6'h28);
    check("bad cmd wiper1", w1, 6'h28);
    check("bad cmd setup", setup, 8'h85);
    wr2(7'h28, 8'h01, 8'h41, aa, ac);
    check("strap ack", aa, 1'b1);
    check("strap wiper", w0, 6'h28);
    comm_en_n <= 1'b1;
    wr2(DEV, 8'h01, 8'h41, aa, ac);
    check("disabled ack", aa, 1'b1);
    check("disabled wiper", w1, 6'h28);
    comm_en_n <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
  endtask
  task automatic t_setup();
    logic aa;
    logic ac;
    int p;
    p = nv_pulses;
    wr2(DEV, 8'hb8, 8'hb8, aa, ac);
    check("setup", setup, 8'h80);
    check("store pulses", 8'(nv_pulses - p), 8'h01);
    t_taper(6'h00, 7'h00);
    t_taper(6'h3e, 7'h3e);
    t_taper(6'h3f, 7'h50);
  endtask
  task automatic t_read();
    logic [7:0] q;
    logic a;
    logic ac;
    wr2(DEV, 8'h05, 8'h79, a, ac);
    mst.start_cond();
    mst.xfer({DEV, 1'b1}, 1'b1, q, a);
    check("read ack", a, 1'b0);
    mst.xfer(8'hff, 1'b0, q, a);
    check("read wiper0", q, 8'h05);
    mst.xfer(8'hff, 1'b0, q, a);
    check("read wiper1", q, 8'h79);
    mst.xfer(8'hff, 1'b0, q, a);
    check("read setup", q, 8'h80);
    mst.xfer(8'hff, 1'b1, q, a);
    check("read wrap", q, 8'h05);
    mst.stop_cond();
  endtask
  task automatic t_gate();
    logic aa;
    logic ac;
    int p;
    t_power(8'h03, 6'h0d, 6'h19, 8'h83, 6'h0d, 6'h19);
    p = nv_pulses;
    wr2(DEV, 8'h0a, 8'h54, aa, ac);
    check("held wiper0", w0, 6'h0d);
    check("held store", 8'(nv_pulses - p), 8'h00);
    zc <= 2'b01;
    repeat (10) @(posedge clk_sys_i);
    check("zc wiper0", w0, 6'h0a);
    check("zc wiper1", w1, 6'h19);
    // Still inside the window here, about 25 cycles before it closes
    repeat (WIN - 80) @(posedge clk_sys_i);
    check("window wiper1", w1, 6'h19);
    check("window store", 8'(nv_pulses - p), 8'h00);
    repeat (80) @(posedge clk_sys_i);
    check("expiry wiper1", w1, 6'h14);
    check("late store", 8'(nv_pulses - p), 8'h01);
    zc <= 2'b00;
  endtask

  initial
  begin
    rstn_i = 1'b0;
    comm_en_n = 1'b0;
    strap = 3'b101;
    zc = 2'b00;
    nv_setup = 8'h05;
    nv_w0 = 6'h11;
    nv_w1 = 6'h12;
    errors = 0;
    tests_run = 0;
    cyc = 0;
    nv_pulses = 0;
    t_power(8'h05, 6'h11, 6'h12, 8'h85, 6'h21, 6'h21);
    t_coarse();
    t_refuse();
    t_setup();
    t_read();
    t_gate();
    end_of_test();
  end
endmodule // tb
`default_nettype wire
